/* File: hw/ord_orient_detect.sv */
// Orientation detection status, configuration and debounce logic.
`timescale 1ns/1ps
module ord_orient_detect #(
	parameter int STEP_CYCLES = ord_pkg::STEP_BASE_CYC
) (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       active_mode,
	input  wire logic       sleep_mode,
	input  wire logic [2:0] output_sample_rate,
	input  wire logic [1:0] osm_sel,
	input  wire logic       over_range,
	input  wire logic [8:0] z_angle_deg,
	input  wire logic [6:0] xy_angle_deg,
	input  wire logic [1:0] lp_candidate,
	output logic            orient_change_flag,
	output logic            ztilt_lockout,
	output logic      [1:0] land_port_code,
	output logic            back_front_bit
);
	initial begin
		if (STEP_CYCLES < 1 || STEP_CYCLES > 32'h7fff_ffff)
			$error("STEP_CYCLES out of range");
		// The limits must leave a held band between back and front, or
		// the answer would flip on every step near the boundary.
		if (ord_pkg::BACK_LO_DEG >= ord_pkg::FRONT_LO_DEG ||
			ord_pkg::BACK_HI_DEG <= ord_pkg::FRONT_HI_DEG)
			$error("back/front limits overlap");
	end

	// Multiples of the base step for each rate and oversampling mode.
	function automatic logic [7:0] step_mult(input logic [2:0] rate,
		input logic [1:0] osm);
		logic [7:0] m;
		m = 8'h01;
		if (rate == ord_pkg::RATE_800)
			m = 8'h01;
		else if (rate == ord_pkg::RATE_400 || osm == ord_pkg::OSM_HIRES)
			m = 8'h02;
		else if (rate == ord_pkg::RATE_200)
			m = 8'h04;
		else if (rate == ord_pkg::RATE_100)
			m = 8'h08;
		else if (rate == ord_pkg::RATE_50 || osm == ord_pkg::OSM_NORMAL)
			m = 8'h10;
		else if (rate == ord_pkg::RATE_12P5 || osm == ord_pkg::OSM_LPLN)
			m = 8'h40;
		else
			m = 8'h80;
		return m;
	endfunction

	// Lockout threshold angle in degrees for each Z-lock code.
	function automatic logic [6:0] angle_a_deg(input logic [2:0] code);
		logic [6:0] d;
		d = 7'h1d;
		case (code)
			3'h0: d = 7'h0e;
			3'h1: d = 7'h12;
			3'h2: d = 7'h15;
			3'h3: d = 7'h19;
			3'h4: d = 7'h1d;
			3'h5: d = 7'h21;
			3'h6: d = 7'h25;
			default: d = 7'h2a;
		endcase
		return d;
	endfunction

	// Read data selection; unmapped offsets return zero.
	function automatic logic [7:0] read_mux(input logic [7:0] addr,
		input logic [7:0] stat, input logic [7:0] cfg,
		input logic [7:0] cnt, input logic [7:0] bfz);
		logic [7:0] v;
		v = 8'h00;
		if (addr == ord_pkg::ADDR_STATUS)
			v = stat;
		else if (addr == ord_pkg::ADDR_CONFIG)
			v = cfg;
		else if (addr == ord_pkg::ADDR_DBCOUNT)
			v = cnt;
		else if (addr == ord_pkg::ADDR_BFZLOCK)
			v = bfz;
		return v;
	endfunction

	// Next debounce count. Wake/sleep changes and disabling restart it so
	// a stale partial count can never complete a later, unrelated change.
	function automatic logic [7:0] dbc_next(input logic [7:0] cnt,
		input logic restart, input logic done, input logic eval,
		input logic diff, input logic clr_mode);
		logic [7:0] n;
		n = cnt;
		if (restart || done)
			n = 8'h00;
		else if (eval && diff)
			n = cnt + 8'h01;
		else if (eval && clr_mode)
			n = 8'h00;
		else if (eval && cnt != 8'h00)
			n = cnt - 8'h01;
		return n;
	endfunction

	logic [7:0] orient_config_r;
	logic [7:0] orient_debounce_count_r;
	logic [7:0] backfront_angle_a_angles_r;
	logic       flag_r;
	logic       lock_r;
	logic [1:0] lp_r;
	logic       bf_r;
	logic [7:0] dbc_r;
	logic       first_r;
	logic       active_d_r;
	logic       sleep_d_r;
	logic [31:0] base_cnt_r;
	logic [7:0] mult_cnt_r;
	logic [7:0] reg_rdata_r;

	wire logic [7:0] status_val;
	wire logic       wr_config;
	wire logic       wr_dbcount;
	wire logic       wr_bfzlock;
	wire logic       rd_status;
	wire logic       det_en;
	wire logic       dbc_mode;
	wire logic [1:0] bf_trip;
	wire logic [8:0] bf_off;
	wire logic       z_back;
	wire logic       z_front;
	wire logic       bf_cand;
	wire logic       lock_cand;
	wire logic       differs;
	wire logic       base_tick;
	wire logic       step_tick;
	wire logic [7:0] mult;
	wire logic       wake_edge;
	wire logic       go_active;
	wire logic       commit;
	wire logic       evaluate;
	wire logic [7:0] dbc_nxt;
	wire logic [7:0] rd_sel;

	assign status_val = {flag_r, lock_r, 3'h0, lp_r, bf_r};
	// Writes to the status offset or unmapped offsets match nothing here.
	assign wr_config  = reg_wr && reg_addr == ord_pkg::ADDR_CONFIG;
	assign wr_dbcount = reg_wr && reg_addr == ord_pkg::ADDR_DBCOUNT;
	assign wr_bfzlock = reg_wr && reg_addr == ord_pkg::ADDR_BFZLOCK;
	assign rd_status  = reg_rd && reg_addr == ord_pkg::ADDR_STATUS;

	assign det_en   = orient_config_r[ord_pkg::CFG_EN_BIT] && active_mode;
	assign dbc_mode = orient_config_r[ord_pkg::CFG_MODE_BIT];
	assign bf_trip  = backfront_angle_a_angles_r[ord_pkg::BF_TRIP_LSB +: 2];

	// The band between the back and front limits keeps the last answer.
	assign bf_off  = 9'(bf_trip) * 9'(ord_pkg::BF_STEP_DEG);
	assign z_back  = z_angle_deg < 9'(ord_pkg::BACK_LO_DEG) - bf_off ||
		z_angle_deg > 9'(ord_pkg::BACK_HI_DEG) + bf_off;
	assign z_front = z_angle_deg > 9'(ord_pkg::FRONT_LO_DEG) + bf_off &&
		z_angle_deg < 9'(ord_pkg::FRONT_HI_DEG) - bf_off;
	assign bf_cand = z_back ? 1'b1 : (z_front ? 1'b0 : bf_r);

	// Lockout while the face plane tilt is below the chosen Z-lock angle.
	assign lock_cand = xy_angle_deg <
		angle_a_deg(backfront_angle_a_angles_r[ord_pkg::ANGLE_A_LSB +: 3]);

	// Any field that would move counts, so lockout alone can carry a change.
	assign differs = {lock_cand, lp_candidate, bf_cand} !=
		{lock_r, lp_r, bf_r};

	// The multiple is compared with >= so a higher rate chosen mid-count
	// ends the step early instead of waiting for the counter to wrap.
	assign mult      = step_mult(output_sample_rate, osm_sel);
	assign base_tick = base_cnt_r == 32'(STEP_CYCLES - 1);
	assign step_tick = base_tick && mult_cnt_r >= mult - 8'h01;

	assign wake_edge = sleep_mode != sleep_d_r;
	assign go_active = active_mode && !active_d_r;

	// Overload freezes both the reported state and the counter.
	assign evaluate = det_en && step_tick && !over_range;
	assign commit   = evaluate && (first_r || (differs &&
		dbc_r + 8'h01 >= orient_debounce_count_r));

	assign dbc_nxt = dbc_next(dbc_r, wake_edge || !det_en, commit,
		evaluate, differs, dbc_mode);
	assign rd_sel  = read_mux(reg_addr, status_val, orient_config_r,
		orient_debounce_count_r, backfront_angle_a_angles_r);

	// Step divider: base steps of STEP_CYCLES, then the rate multiple.
	// Disabling restarts it, so the first step after enable is a full one.

	always_ff @(posedge core_clk) begin
		if (sys_rst || !det_en) begin
			base_cnt_r <= 32'h0000_0000;
			mult_cnt_r <= 8'h00;
		end else if (base_tick) begin
			base_cnt_r <= 32'h0000_0000;
			mult_cnt_r <= step_tick ? 8'h00 : mult_cnt_r + 8'h01;
		end else begin
			base_cnt_r <= base_cnt_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			orient_config_r          <= ord_pkg::CONFIG_RST;
			orient_debounce_count_r  <= ord_pkg::DBCOUNT_RST;
			backfront_angle_a_angles_r <= ord_pkg::BFZLOCK_RST;
		end else begin
			if (wr_config)
				orient_config_r <= reg_wdata & ord_pkg::CONFIG_MASK;
			if (wr_dbcount)
				orient_debounce_count_r <= reg_wdata;
			if (wr_bfzlock)
				backfront_angle_a_angles_r <= reg_wdata & ord_pkg::BFZLOCK_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			// Reset counts as standby; a level held at release must not
			// read as a wake/sleep change.
			active_d_r <= 1'b0;
			sleep_d_r  <= sleep_mode;
			first_r    <= 1'b0;
		end else begin
			active_d_r <= active_mode;
			sleep_d_r  <= sleep_mode;
			if (go_active)
				first_r <= 1'b1;
			else if (commit)
				first_r <= 1'b0;
		end
	end

	// Debounce counter.
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			dbc_r <= 8'h00;
		else
			dbc_r <= dbc_nxt;
	end

	// Status fields; a commit lands even while the change flag is set.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lock_r <= 1'b0;
			lp_r   <= 2'b00;
			bf_r   <= 1'b0;
		end else if (commit) begin
			lock_r <= lock_cand;
			lp_r   <= lp_candidate;
			bf_r   <= bf_cand;
		end
	end

	// A new change in the read cycle wins over the clear.
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			flag_r <= 1'b0;
		else if (commit && (first_r || differs))
			flag_r <= 1'b1;
		else if (rd_status)
			flag_r <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst)
			reg_rdata_r <= 8'h00;
		else if (reg_rd)
			reg_rdata_r <= rd_sel;
	end

	// Status pins mirror the register bits so a host need not poll.
	assign reg_rdata          = reg_rdata_r;
	assign orient_change_flag = flag_r;
	assign ztilt_lockout      = lock_r;
	assign land_port_code     = lp_r;
	assign back_front_bit     = bf_r;
endmodule

/* File: hw/ord_pkg.sv */
// Register map, field layout, reset values and timing for orientation detect.
package ord_pkg;
	localparam logic [7:0] ADDR_STATUS   = 8'h10;
	localparam logic [7:0] ADDR_CONFIG   = 8'h11;
	localparam logic [7:0] ADDR_DBCOUNT  = 8'h12;
	localparam logic [7:0] ADDR_BFZLOCK  = 8'h13;

	localparam int STAT_FLAG_BIT  = 7;
	localparam int STAT_LOCK_BIT  = 6;
	localparam int STAT_LP_LSB    = 1;
	localparam int STAT_BF_BIT    = 0;
	localparam int CFG_MODE_BIT   = 7;
	localparam int CFG_EN_BIT     = 6;
	localparam int BF_TRIP_LSB    = 6;
	localparam int ANGLE_A_LSB      = 0;

	localparam logic [7:0] CONFIG_RST  = 8'h80;
	localparam logic [7:0] DBCOUNT_RST = 8'h00;
	localparam logic [7:0] BFZLOCK_RST = 8'h44;
	localparam logic [7:0] CONFIG_MASK  = 8'hc0;
	localparam logic [7:0] BFZLOCK_MASK = 8'hc7;

	// Back/front trip angles in degrees for trip code zero, 5 degree step.
	localparam int BACK_LO_DEG   = 80;
	localparam int BACK_HI_DEG   = 280;
	localparam int FRONT_LO_DEG  = 100;
	localparam int FRONT_HI_DEG  = 260;
	localparam int BF_STEP_DEG   = 5;

	// Base debounce step at the fastest sample rate.
	localparam int STEP_BASE_NS   = 1_250_000;
	localparam int CLK_PERIOD_NS  = 5;
	localparam int STEP_BASE_CYC  = STEP_BASE_NS / CLK_PERIOD_NS;

	// Sample rate codes, fastest first.
	localparam logic [2:0] RATE_800  = 3'h0;
	localparam logic [2:0] RATE_400  = 3'h1;
	localparam logic [2:0] RATE_200  = 3'h2;
	localparam logic [2:0] RATE_100  = 3'h3;
	localparam logic [2:0] RATE_50   = 3'h4;
	localparam logic [2:0] RATE_12P5 = 3'h5;

	typedef enum logic [1:0] {
		OSM_NORMAL = 2'h0,
		OSM_LPLN   = 2'h1,
		OSM_HIRES  = 2'h2,
		OSM_LP     = 2'h3
	} ord_osm_type;
endpackage

/* File: tb/ord_orient_detect_checker.sv */
// Port-level checker for the orientation detect register block.
`timescale 1ns/1ps
module ord_orient_detect_checker #(
	parameter int STEP_CYCLES = 4
) (
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       active_mode,
	input wire logic       over_range,
	input wire logic       orient_change_flag,
	input wire logic       ztilt_lockout,
	input wire logic [1:0] land_port_code,
	input wire logic       back_front_bit
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire logic [3:0] fields = {ztilt_lockout, land_port_code, back_front_bit};
	wire logic [7:0] status = {orient_change_flag, ztilt_lockout, 3'h0,
		land_port_code, back_front_bit};
	wire logic       rd_stat = reg_rd && reg_addr == ord_pkg::ADDR_STATUS;
	wire logic       rd_bad = reg_rd && (reg_addr < ord_pkg::ADDR_STATUS ||
		reg_addr > ord_pkg::ADDR_BFZLOCK);

	a_reset_clears: assert property (disable iff (1'b0)
		sys_rst |=> status == 8'h00 && reg_rdata == 8'h00)
		else $error("status or read data not zero after reset");
	a_change_sets_flag: assert property (!$stable(fields) |-> orient_change_flag)
		else $error("status changed without change flag");
	a_read_clears_flag: assert property (rd_stat && over_range |=> !orient_change_flag)
		else $error("status read did not clear change flag");
	a_overrange_hold: assert property ($past(over_range) |-> $stable(fields))
		else $error("orientation moved while over range");
	a_idle_hold: assert property (!$past(active_mode) |-> $stable(fields))
		else $error("orientation moved while not active");
	a_status_layout: assert property (rd_stat |=> reg_rdata == $past(status))
		else $error("status read data does not match status bits");
	a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (rd_bad |=> reg_rdata == 8'h00)
		else $error("unmapped read returned nonzero");
endmodule

bind ord_orient_detect ord_orient_detect_checker #(.STEP_CYCLES(STEP_CYCLES)) i_chk (
	.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .active_mode(active_mode),
	.over_range(over_range), .orient_change_flag(orient_change_flag),
	.ztilt_lockout(ztilt_lockout), .land_port_code(land_port_code),
	.back_front_bit(back_front_bit));

/* File: tb/tb_ord_orient_detect.sv */
// Self-checking bench for the orientation detect register block.
`timescale 1ns/1ps
module tb_ord_orient_detect;
	logic       core_clk, sys_rst, reg_wr, reg_rd, active_mode, over_range;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, r;
	logic [8:0] z_angle_deg;
	logic [6:0] xy_angle_deg;
	logic [1:0] lp_candidate;
	logic       flag, lock, bf;
	logic [1:0] lp;
	logic       sleep_mode;
	logic [2:0] rate_sel;
	logic [1:0] osm;
	int         fails, n_tests, cyc, seed, step_len;
	localparam int STEP = 4;
	// Debounce step in base steps, by sample rate (row) and oversampling
	// mode (column: normal, low-noise, high-res, low-power).
	int         mult_tbl [8][4] = '{'{1, 1, 1, 1}, '{2, 2, 2, 2},
		'{4, 4, 2, 4}, '{8, 8, 2, 8}, '{16, 16, 2, 16},
		'{16, 64, 2, 64}, '{16, 64, 2, 128}, '{16, 64, 2, 128}};
	logic [7:0] ra [5] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
	logic [7:0] re [5] = '{8'h00, 8'h80, 8'h00, 8'h44, 8'h00};

	ord_orient_detect #(.STEP_CYCLES(STEP)) i_ord_orient_detect (
		.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .active_mode(active_mode),
		.sleep_mode(sleep_mode), .output_sample_rate(rate_sel),
		.osm_sel(osm),
		.over_range(over_range), .z_angle_deg(z_angle_deg),
		.xy_angle_deg(xy_angle_deg), .lp_candidate(lp_candidate),
		.orient_change_flag(flag), .ztilt_lockout(lock),
		.land_port_code(lp), .back_front_bit(bf));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	function automatic logic [7:0] stat(input logic f, l,
		input logic [1:0] c, input logic b);
		return {f, l, 3'h0, c, b};
	endfunction

	function automatic int step_cyc(input logic [2:0] r,
		input logic [1:0] m);
		return STEP * mult_tbl[r][m];
	endfunction

	task automatic summarize();
		$display("counts: %0d compares, %0d mismatches", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Strobes get a quiet cycle after them so back-to-back calls never
	// assign a strobe twice in one time step.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge core_clk); #1 reg_wr = 1'b0;
		@(posedge core_clk); #1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge core_clk); #1 reg_rd = 1'b0;
		v = reg_rdata;
		@(posedge core_clk); #1;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// A window of whole steps holds exactly that many step ticks.
	task automatic hold(input logic [1:0] c, input int steps);
		lp_candidate = c;
		idle(steps * step_len);
	endtask

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			summarize();
		end
	end

	initial begin
		seed = 88487;
		{reg_wr, reg_rd, active_mode, over_range, reg_addr, reg_wdata} = '0;
		{lp_candidate, z_angle_deg, xy_angle_deg} = {2'h0, 9'd180, 7'd60};
		{sleep_mode, rate_sel, osm} = '0;
		sys_rst = 1'b1;
		repeat (6) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(ra[i], d);
			check(d, re[i]);
		end
		wr(8'h11, 8'hff);
		rd(8'h11, d);
		check(d, 8'hc0);
		wr(8'h13, 8'hff);
		rd(8'h13, d);
		check(d, 8'hc7);
		wr(8'h13, 8'h44);
		wr(8'h10, 8'hff);
		rd(8'h10, d);
		check(d, 8'h00);
		r = 8'($random(seed));
		wr(8'h12, r);
		rd(8'h12, d);
		check(d, r);
		$display("register tests done");
		wr(8'h12, 8'h00);
		active_mode = 1'b1;
		for (int i = 0; i < 4; i++) begin
			lp_candidate = 2'(i);
			z_angle_deg = i[0] ? 9'd0 : 9'd180;
			xy_angle_deg = i[1] ? 7'($unsigned($random(seed)) % 29) : 7'd60;
			idle(20);
			rd(8'h10, d);
			check(d, stat(1'b1, xy_angle_deg < 29, 2'(i), i[0]));
			rd(8'h10, d);
			check(d, stat(1'b0, xy_angle_deg < 29, 2'(i), i[0]));
		end
		$display("orientation tests done");
		over_range = 1'b1;
		lp_candidate = 2'h0;
		idle(20);
		rd(8'h10, d);
		check(d, stat(1'b0, 1'b1, 2'h3, 1'b1));
		over_range = 1'b0;
		idle(20);
		over_range = 1'b1;
		rd(8'h10, d);
		check(d, stat(1'b1, 1'b1, 2'h0, 1'b1));
		over_range = 1'b0;
		wr(8'h12, 8'h05);
		lp_candidate = 2'h2;
		idle(8);
		rd(8'h10, d);
		check(d, stat(1'b0, 1'b1, 2'h0, 1'b1));
		idle(40);
		rd(8'h10, d);
		check(d, stat(1'b1, 1'b1, 2'h2, 1'b1));
		wr(8'h11, 8'h80);
		lp_candidate = 2'h1;
		idle(40);
		rd(8'h10, d);
		check(d, stat(1'b0, 1'b1, 2'h2, 1'b1));
		// Decrement mode: three steps differ, one agrees, three differ.
		{rate_sel, osm} = {ord_pkg::RATE_100, ord_pkg::OSM_LP};
		step_len = step_cyc(rate_sel, osm);
		lp_candidate = 2'h2;
		wr(8'h11, 8'h40);
		hold(2'h1, 3);
		hold(2'h2, 1);
		hold(2'h1, 3);
		rd(8'h10, d);
		check(d, stat(1'b1, 1'b1, 2'h1, 1'b1));
		// Clear mode: the same pattern falls short until two more steps.
		wr(8'h11, 8'h80);
		{rate_sel, osm} = {ord_pkg::RATE_200, ord_pkg::OSM_HIRES};
		step_len = step_cyc(rate_sel, osm);
		wr(8'h11, 8'hc0);
		hold(2'h3, 3);
		hold(2'h1, 1);
		hold(2'h3, 3);
		rd(8'h10, d);
		check(d, stat(1'b0, 1'b1, 2'h1, 1'b1));
		idle(2 * step_len);
		rd(8'h10, d);
		check(d, stat(1'b1, 1'b1, 2'h3, 1'b1));
		// A sleep change in mid-count starts the debounce over.
		hold(2'h0, 3);
		sleep_mode = 1'b1;
		idle(3 * step_len);
		rd(8'h10, d);
		check(d, stat(1'b0, 1'b1, 2'h3, 1'b1));
		idle(2 * step_len);
		rd(8'h10, d);
		check(d, stat(1'b1, 1'b1, 2'h0, 1'b1));
		$display("debounce and enable tests done");
		sys_rst = 1'b1;
		idle(2);
		sys_rst = 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(ra[i], d);
			check(d, re[i]);
		end
		$display("reset tests done");
		summarize();
	end
endmodule
